// ### rld_pkg.sv
// Purpose : Shared constants and carriers of the regulator and LED dim control block
// Assumes : One 20 MHz clock, byte wide register port
// Notes   : Times are held in their own unit; cycle counts derive from the clock rate

`default_nettype none

package rld_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int CLK_HZ        = 20_000_000;           // Core clock rate
  localparam int CLK_KHZ       = CLK_HZ / 1000;        // Cycles per millisecond
  localparam int SHORT_MS      = 15;                   // Under-voltage time before shutdown
  localparam int COOL_MS       = 120;                  // Cool-down before restart
  localparam int SOFT_MS       = 2;                    // Soft-start ramp length
  localparam int SHORT_CYC     = SHORT_MS * CLK_KHZ;   // Longest time, exact here
  localparam int COOL_CYC      = COOL_MS * CLK_KHZ;    // Least time, exact here
  localparam int SOFT_CYC      = SOFT_MS * CLK_KHZ;    // Ramp length in cycles
  localparam int CNT_W         = 22;                   // Timer width, holds COOL_CYC

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFS_MAIN_CONTROL  = 8'h04;    // main_control
  localparam logic [7:0] OFS_AUX_TEST      = 8'h6e;    // aux_voltage_test_control
  localparam logic [7:0] OFS_INT_DIM       = 8'h10;    // internal_dim_level
  localparam logic [7:0] OFS_POS_STATUS    = 8'h20;    // positive_status
  localparam logic [7:0] OFS_POS_MASK      = 8'h21;    // positive_interrupt_mask

  // Field positions
  localparam int BIT_AUX_ENABLE  = 0;                  // main_control: aux regulator run
  localparam int BIT_LED_ENABLE  = 1;                  // main_control: LED driver run
  localparam int BIT_INT_DIM_SEL = 7;                  // internal_dim_level: DAC select
  localparam int BIT_AUX_FAULT   = 0;                  // status and mask: aux latch-off

  // Values after reset
  localparam logic [7:0] RST_MAIN_CONTROL = 8'h00;     // Both converters idle
  localparam logic [7:0] RST_AUX_TEST     = 8'h02;     // Select code 010b, 5 V
  localparam logic [7:0] RST_INT_DIM      = 8'h00;     // DAC at zero, not selected
  localparam logic [7:0] RST_POS_STATUS   = 8'h00;     // No events
  localparam logic [7:0] RST_POS_MASK     = 8'h00;     // All events unmasked

  //////////////////////////////////////////////////////////////////////////////
  // Converter sequencer states
  typedef enum logic [4:0] {
    RLD_OFF   = 5'h01,
    RLD_SOFT  = 5'h02,
    RLD_RUN   = 5'h04,
    RLD_COOL  = 5'h08,
    RLD_LATCH = 5'h10
  } rld_conv_state_t;

  // Dim control node source
  typedef enum logic [2:0] {
    RLD_DIM_ZERO   = 3'h1,
    RLD_DIM_ANALOG = 3'h2,
    RLD_DIM_DAC    = 3'h4
  } rld_dim_src_t;

  // Dim routing carrier
  typedef struct packed {
    rld_dim_src_t src;                                 // Selected source
    logic [6:0]   code;                                // DAC code, 128 steps
  } rld_dim_t;

endpackage

`default_nettype wire

// ### rld_conv_seq.sv
// Purpose : Start-up and protection sequencer of one DC-DC converter
// Assumes : Fault inputs are synchronous, enable held by software
// Notes   : Used for both the main and the auxiliary regulator

`timescale 1ns/10ps
`default_nettype none

module rld_conv_seq #(
  parameter int SHORT_CYC = rld_pkg::SHORT_CYC,        // Under-voltage window
  parameter int COOL_CYC  = rld_pkg::COOL_CYC,         // Cool-down length
  parameter int SOFT_CYC  = rld_pkg::SOFT_CYC          // Soft-start length
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // Control and sense
  input  wire logic enable_in,                         // Software enable
  input  wire logic out_low_in,                        // Output well below target
  input  wire logic vds_high_in,                       // Excess drain-source voltage
  // Power stage
  output logic      run_out,                           // Switching allowed
  output logic      soft_start_out,                    // Ramp in progress
  output logic      latch_evt_out                      // One-cycle latch-off event
);

  localparam int W = rld_pkg::CNT_W;

  if (SHORT_CYC < 1 || COOL_CYC < 1 || SOFT_CYC < 1 || COOL_CYC >= (1 << W) ||
      SHORT_CYC >= (1 << W) || SOFT_CYC >= (1 << W)) begin : g_chk
    $error("rld_conv_seq: timer values out of range");
  end

  localparam logic [W-1:0] SHORT_M1 = W'(SHORT_CYC - 1);
  localparam logic [W-1:0] COOL_M1  = W'(COOL_CYC - 1);
  localparam logic [W-1:0] SOFT_M1  = W'(SOFT_CYC - 1);

  typedef struct packed {
    rld_pkg::rld_conv_state_t state;                   // Sequencer state
    logic [W-1:0]             cnt;                     // Shared timer
    logic                     run;
    logic                     ss;
    logic                     evt;
  } rld_conv_st_t;

  rld_conv_st_t st;                                    // Current state
  rld_conv_st_t next_st;                               // Next state

  //////////////////////////////////////////////////////////////////////////////
  // Next state; a switch overload wins over the soft-start and under-voltage timers
  always_comb begin
    next_st     = st;
    next_st.evt = 1'b0;
    case (st.state)
      rld_pkg::RLD_OFF: begin
        next_st.cnt = '0;
        if (enable_in) begin
          next_st.state = rld_pkg::RLD_SOFT;
        end
      end
      rld_pkg::RLD_SOFT: begin
        // Output is still low while ramping, so it is not counted here
        if (!enable_in) begin
          next_st.state = rld_pkg::RLD_OFF;
        end else if (vds_high_in) begin
          next_st.state = rld_pkg::RLD_LATCH;
          next_st.evt   = 1'b1;
        end else if (st.cnt == SOFT_M1) begin
          next_st.state = rld_pkg::RLD_RUN;
          next_st.cnt   = '0;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      rld_pkg::RLD_RUN: begin
        if (!enable_in) begin
          next_st.state = rld_pkg::RLD_OFF;
        end else if (vds_high_in) begin
          next_st.state = rld_pkg::RLD_LATCH;
          next_st.evt   = 1'b1;
        end else if (!out_low_in) begin
          next_st.cnt = '0;
        end else if (st.cnt == SHORT_M1) begin
          next_st.state = rld_pkg::RLD_COOL;
          next_st.cnt   = '0;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      rld_pkg::RLD_COOL: begin
        if (!enable_in) begin
          next_st.state = rld_pkg::RLD_OFF;
        end else if (st.cnt == COOL_M1) begin
          next_st.state = rld_pkg::RLD_SOFT;
          next_st.cnt   = '0;
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      rld_pkg::RLD_LATCH: begin
        // Only a software re-enable (clear then set) leaves the latch
        if (!enable_in) begin
          next_st.state = rld_pkg::RLD_OFF;
        end
      end
      default: begin
        next_st.state = rld_pkg::RLD_OFF;
        next_st.cnt   = '0;
      end
    endcase
    next_st.run = (next_st.state == rld_pkg::RLD_SOFT) || (next_st.state == rld_pkg::RLD_RUN);
    next_st.ss  = (next_st.state == rld_pkg::RLD_SOFT);
  end

  // State register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '{state: rld_pkg::RLD_OFF, cnt: '0, run: 1'b0, ss: 1'b0, evt: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign run_out        = st.run;
  assign soft_start_out = st.ss;
  assign latch_evt_out  = st.evt;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_soft_first: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st.state == rld_pkg::RLD_OFF && enable_in) |=> (soft_start_out && run_out))
    else $error("start-up did not begin with soft-start");
  a_short_off: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st.state == rld_pkg::RLD_RUN && enable_in && !vds_high_in && out_low_in &&
     st.cnt == SHORT_M1) |=> (!run_out ##1 !run_out))
    else $error("converter not shut down after under-voltage window");
  a_cool_restart: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st.state == rld_pkg::RLD_COOL && enable_in && st.cnt == COOL_M1) |=> soft_start_out)
    else $error("converter did not restart after cool-down");
  a_latch_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st.state == rld_pkg::RLD_LATCH && enable_in) |=>
      (!run_out && st.state == rld_pkg::RLD_LATCH))
    else $error("latched converter switched again");

endmodule // rld_conv_seq

`default_nettype wire

// ### rld_dim_route.sv
// Purpose : Selects the source of the LED dim control node
// Assumes : PWM pin synchronous to the clock
// Notes   : Internal DAC selection overrides the PWM and analog paths

`timescale 1ns/10ps
`default_nettype none

module rld_dim_route (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // Sources
  input  wire logic              pwm_in,               // PWM dimming pin
  input  wire logic              int_sel_in,           // internal_dim_select
  input  wire logic [6:0]        level_in,             // internal DAC code
  // Dim control node routing
  output rld_pkg::rld_dim_t      dim_out
);

  rld_pkg::rld_dim_t st;                               // Registered routing
  rld_pkg::rld_dim_t next_st;                          // Next routing

  //////////////////////////////////////////////////////////////////////////////
  // Source priority: DAC, then PWM gate over the analog input
  always_comb begin
    next_st.code = level_in;
    if (int_sel_in) begin
      next_st.src = rld_pkg::RLD_DIM_DAC;
    end else if (pwm_in) begin
      next_st.src = rld_pkg::RLD_DIM_ANALOG;
    end else begin
      next_st.src = rld_pkg::RLD_DIM_ZERO;
    end
  end

  // Routing register; reset parks the node at zero current
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '{src: rld_pkg::RLD_DIM_ZERO, code: 7'h00};
    end else begin
      st <= next_st;
    end
  end

  assign dim_out = st;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_dac_wins: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    int_sel_in |=> (dim_out.src == rld_pkg::RLD_DIM_DAC && dim_out.code == $past(level_in)))
    else $error("internal DAC did not own the dim node");
  a_pwm_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!int_sel_in && !pwm_in) |=> dim_out.src == rld_pkg::RLD_DIM_ZERO)
    else $error("PWM low did not force zero current");
  a_pwm_analog: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (!int_sel_in && pwm_in) |=> dim_out.src == rld_pkg::RLD_DIM_ANALOG)
    else $error("PWM high did not pass the analog input");

endmodule // rld_dim_route

`default_nettype wire

// ### rld_top.sv
// Purpose : Register file, regulator sequencing, fault status and dim routing
// Assumes : Byte register port driven by the serial interface, one clock
// Notes   : Long timers are parameters so that simulation can shorten them

`timescale 1ns/10ps
`default_nettype none

module rld_top #(
  parameter int SHORT_CYC = rld_pkg::SHORT_CYC,        // 15 ms window in cycles
  parameter int COOL_CYC  = rld_pkg::COOL_CYC,         // 120 ms cool-down in cycles
  parameter int SOFT_CYC  = rld_pkg::SOFT_CYC          // Soft-start length in cycles
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // Register port
  input  wire logic [7:0]        reg_addr_in,          // Register offset
  input  wire logic [7:0]        reg_wdata_in,         // Write data
  input  wire logic              reg_wr_in,            // Write strobe, one cycle
  input  wire logic              reg_rd_in,            // Read strobe, one cycle
  output logic      [7:0]        reg_rdata_out,        // Read data, one cycle later
  // Converter sense
  input  wire logic              main_low_in,          // main_regulator output low
  input  wire logic              main_vds_high_in,     // main_regulator switch overload
  input  wire logic              aux_low_in,           // aux_regulator output low
  input  wire logic              aux_vds_high_in,      // aux_regulator switch overload
  // Converter control
  output logic                   main_run_out,         // main_regulator switching
  output logic                   main_soft_start_out,  // main_regulator ramping
  output logic                   aux_run_out,          // aux_regulator switching
  output logic                   aux_soft_start_out,   // aux_regulator ramping
  output logic      [2:0]        aux_voltage_select_out, // aux target code
  // LED driver
  input  wire logic              pwm_in,               // PWM dimming pin
  output logic                   led_driver_enable_out, // Buck controller running
  output rld_pkg::rld_dim_t      dim_control_node_out, // Dim source and DAC code
  // Interrupt
  output logic                   interrupt_out_n       // Active low
);

  //////////////////////////////////////////////////////////////////////////////
  // Register state
  typedef struct packed {
    logic [7:0] main_control;                          // Enables
    logic [7:0] aux_test;                              // Voltage select in [2:0]
    logic [7:0] int_dim;                               // Select in [7], code in [6:0]
    logic [7:0] pos_status;                            // Sticky events
    logic [7:0] pos_mask;                              // 1 masks the event
    logic [7:0] rdata;                                 // Read data holder
    logic       irq_n;                                 // Interrupt pin flop
  } rld_reg_st_t;

  rld_reg_st_t st;                                     // Current registers
  rld_reg_st_t next_st;                                // Next registers

  logic aux_fault_evt;                                 // aux_regulator latch-off pulse
  logic wr_ctrl;                                       // Write decodes
  logic wr_test;
  logic wr_dim;
  logic wr_stat;
  logic wr_mask;

  // Address decode; unmapped writes are dropped silently
  assign wr_ctrl = reg_wr_in && (reg_addr_in == rld_pkg::OFS_MAIN_CONTROL);
  assign wr_test = reg_wr_in && (reg_addr_in == rld_pkg::OFS_AUX_TEST);
  assign wr_dim  = reg_wr_in && (reg_addr_in == rld_pkg::OFS_INT_DIM);
  assign wr_stat = reg_wr_in && (reg_addr_in == rld_pkg::OFS_POS_STATUS);
  assign wr_mask = reg_wr_in && (reg_addr_in == rld_pkg::OFS_POS_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // Register next values
  always_comb begin
    next_st = st;
    if (wr_ctrl) begin
      next_st.main_control = reg_wdata_in;
    end
    // A write while the aux regulator runs still lands; the host must avoid it
    if (wr_test) begin
      next_st.aux_test = reg_wdata_in;
    end
    if (wr_dim) begin
      next_st.int_dim = reg_wdata_in;
    end
    if (wr_mask) begin
      next_st.pos_mask = reg_wdata_in;
    end
    // Write one to clear; a new event in the same cycle wins over the clear
    if (wr_stat) begin
      next_st.pos_status = st.pos_status & ~reg_wdata_in;
    end
    next_st.pos_status[7:1] = 7'h00;
    if (aux_fault_evt) begin
      next_st.pos_status[rld_pkg::BIT_AUX_FAULT] = 1'b1;
    end
    // Pin follows stored status, so it stays low until every unmasked bit clears
    next_st.irq_n = ~|(st.pos_status & ~st.pos_mask);
    // Read mux; unmapped offsets read zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        rld_pkg::OFS_MAIN_CONTROL: next_st.rdata = st.main_control;
        rld_pkg::OFS_AUX_TEST:     next_st.rdata = st.aux_test;
        rld_pkg::OFS_INT_DIM:      next_st.rdata = st.int_dim;
        rld_pkg::OFS_POS_STATUS:   next_st.rdata = st.pos_status;
        rld_pkg::OFS_POS_MASK:     next_st.rdata = st.pos_mask;
        default:                   next_st.rdata = 8'h00;
      endcase
    end
  end

  // Register flops
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st.main_control <= rld_pkg::RST_MAIN_CONTROL;
      st.aux_test     <= rld_pkg::RST_AUX_TEST;
      st.int_dim      <= rld_pkg::RST_INT_DIM;
      st.pos_status   <= rld_pkg::RST_POS_STATUS;
      st.pos_mask     <= rld_pkg::RST_POS_MASK;
      st.rdata        <= 8'h00;
      st.irq_n        <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main regulator runs from reset on; it has no enable bit
  rld_conv_seq #(
    .SHORT_CYC (SHORT_CYC),
    .COOL_CYC  (COOL_CYC),
    .SOFT_CYC  (SOFT_CYC)
  ) u_main_seq (
    .clk_in         (clk_in),
    .arst_n_in      (arst_n_in),
    .enable_in      (1'b1),
    .out_low_in     (main_low_in),
    .vds_high_in    (main_vds_high_in),
    .run_out        (main_run_out),
    .soft_start_out (main_soft_start_out),
    .latch_evt_out  ()
  );

  // Auxiliary regulator under software control
  rld_conv_seq #(
    .SHORT_CYC (SHORT_CYC),
    .COOL_CYC  (COOL_CYC),
    .SOFT_CYC  (SOFT_CYC)
  ) u_aux_seq (
    .clk_in         (clk_in),
    .arst_n_in      (arst_n_in),
    .enable_in      (st.main_control[rld_pkg::BIT_AUX_ENABLE]),
    .out_low_in     (aux_low_in),
    .vds_high_in    (aux_vds_high_in),
    .run_out        (aux_run_out),
    .soft_start_out (aux_soft_start_out),
    .latch_evt_out  (aux_fault_evt)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Dim routing; the host hands over to the DAC before a reflash
  rld_dim_route u_dim (
    .clk_in     (clk_in),
    .arst_n_in  (arst_n_in),
    .pwm_in     (pwm_in),
    .int_sel_in (st.int_dim[rld_pkg::BIT_INT_DIM_SEL]),
    .level_in   (st.int_dim[6:0]),
    .dim_out    (dim_control_node_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops
  assign reg_rdata_out          = st.rdata;
  assign aux_voltage_select_out = st.aux_test[2:0];
  assign led_driver_enable_out  = st.main_control[rld_pkg::BIT_LED_ENABLE];
  assign interrupt_out_n        = st.irq_n;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sel_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    wr_test |=> (aux_voltage_select_out == $past(reg_wdata_in[2:0])))
    else $error("aux voltage select did not take the written code");
  a_fault_sets: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    aux_fault_evt |=> st.pos_status[rld_pkg::BIT_AUX_FAULT] ##1 !interrupt_out_n || st.pos_mask[0])
    else $error("aux fault event lost or interrupt missing");
  a_irq_follow: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st.pos_status[0] && !st.pos_mask[0]) |=> !interrupt_out_n)
    else $error("unmasked status did not raise the interrupt");
  a_irq_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    (st.pos_status == 8'h00 || st.pos_mask[0]) |=> interrupt_out_n)
    else $error("interrupt asserted with nothing unmasked");
  a_led_enable: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    wr_ctrl |=> (led_driver_enable_out == $past(reg_wdata_in[1])))
    else $error("LED enable did not follow the control write");

  c_aux_latch:  cover property (@(posedge clk_in) disable iff (!arst_n_in) aux_fault_evt);
  c_irq_clear:  cover property (@(posedge clk_in) disable iff (!arst_n_in)
    !interrupt_out_n ##1 wr_stat ##2 interrupt_out_n);
  c_dac_owner:  cover property (@(posedge clk_in) disable iff (!arst_n_in)
    dim_control_node_out.src == rld_pkg::RLD_DIM_DAC);
  c_aux_run:    cover property (@(posedge clk_in) disable iff (!arst_n_in)
    aux_soft_start_out ##1 (aux_run_out && !aux_soft_start_out));

endmodule // rld_top

`default_nettype wire

// ### rld_host_model.sv
// Purpose: Host model that drives the byte register port
// Assumes: Strobes change on falling clock edges only
// Notes: Write data is inverted once released, so stale data is never seen

`timescale 1ns/10ps
`default_nettype none

module rld_host_model (
  // Clock
  input  wire logic       clk_in,
  // Register port
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  input  wire logic [7:0] rdata_in
);
  // Idle bus at time zero
  initial {addr_out, wdata_out, wr_out, rd_out} = 18'h0;

  // One write, strobe held across one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
    @(negedge clk_in);
    {wdata_out, wr_out} = {~d, 1'b0};
  endtask

  // One read, data taken after the answering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    {addr_out, rd_out} = {a, 1'b1};
    @(negedge clk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask
endmodule // rld_host_model

`default_nettype wire

// ### regulator_led_dim_control_tb.sv
// Purpose: Self-checking bench of the regulator and dim control block
// Assumes: Timers shortened to 20, 40 and 5 cycles
// Notes: Main regulator sense inputs are tied quiet

`timescale 1ns/10ps
`default_nettype none

module regulator_led_dim_control_tb;
  localparam int SH = 20;
  localparam int CO = 40;
  localparam int SO = 5;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr, wdata, rdata, rv;
  logic wr, rd, arun, asoft, led, int_n, pwm = 1'b0, alow = 1'b0, avds = 1'b0;
  logic mrun, msoft;
  logic [2:0] vsel;
  rld_pkg::rld_dim_t dim;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;

  // 20 MHz clock
  always #25 clk_in = ~clk_in;

  rld_top #(.SHORT_CYC(SH), .COOL_CYC(CO), .SOFT_CYC(SO)) rld_top_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .main_low_in(1'b0),
    .main_vds_high_in(1'b0), .aux_low_in(alow), .aux_vds_high_in(avds), .main_run_out(mrun),
    .main_soft_start_out(msoft), .aux_run_out(arun), .aux_soft_start_out(asoft),
    .aux_voltage_select_out(vsel), .pwm_in(pwm), .led_driver_enable_out(led),
    .dim_control_node_out(dim), .interrupt_out_n(int_n));

  rld_host_model rld_host_model_inst (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd), .rdata_in(rdata));

  ////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic nw(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Hang guard, far above the expected run of about 140 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      summarize();
    end
  end

  ////////////////////////////////////////
  task automatic t_select;
    chk("main", 8'h03, {6'h0, mrun, msoft});
    chk("sel", 8'h02, {5'h0, vsel});
    chk("led", 8'h00, {7'h0, led});
    rld_host_model_inst.rd(rld_pkg::OFS_AUX_TEST, rv);
    chk("aux_test", 8'h02, rv);
    for (int i = 0; i < 8; i++) begin
      rld_host_model_inst.wr(rld_pkg::OFS_AUX_TEST, 8'(i));
      chk("sel", 8'(i), {5'h0, vsel});
    end
  endtask

  task automatic t_start;
    chk("aux_run", 8'h00, {7'h0, arun});
    rld_host_model_inst.wr(rld_pkg::OFS_MAIN_CONTROL, 8'h03);
    nw(1);
    chk("aux_run", 8'h01, {7'h0, arun});
    chk("aux_soft", 8'h01, {7'h0, asoft});
    chk("led", 8'h01, {7'h0, led});
    nw(SO - 2);
    chk("aux_soft", 8'h01, {7'h0, asoft});
    nw(4);
    chk("aux_soft", 8'h00, {7'h0, asoft});
  endtask

  // Output held low: shut down, cool down, restart with a ramp
  task automatic t_short;
    alow = 1'b1;
    nw(SH - 1);
    chk("aux_run", 8'h01, {7'h0, arun});
    nw(1);
    chk("aux_run", 8'h00, {7'h0, arun});
    alow = 1'b0;
    nw(CO - 1);
    chk("aux_run", 8'h00, {7'h0, arun});
    nw(1);
    chk("aux_restart", 8'h03, {6'h0, arun, asoft});
    nw(SO + 2);
  endtask

  // Switch overload: latch-off, status, mask and clear
  task automatic t_fault;
    avds = 1'b1;
    nw(1);
    avds = 1'b0;
    chk("aux_run", 8'h00, {7'h0, arun});
    nw(3);
    chk("int_n", 8'h00, {7'h0, int_n});
    rld_host_model_inst.rd(rld_pkg::OFS_POS_STATUS, rv);
    chk("status", 8'h01, rv);
    rld_host_model_inst.wr(rld_pkg::OFS_POS_MASK, 8'h01);
    nw(1);
    chk("int_n", 8'h01, {7'h0, int_n});
    rld_host_model_inst.wr(rld_pkg::OFS_POS_MASK, 8'h00);
    nw(1);
    chk("int_n", 8'h00, {7'h0, int_n});
    rld_host_model_inst.wr(rld_pkg::OFS_POS_STATUS, 8'h01);
    nw(1);
    chk("int_n", 8'h01, {7'h0, int_n});
    chk("aux_run", 8'h00, {7'h0, arun});
    // Clear then set the enable: the latch lets go and a ramp follows
    rld_host_model_inst.wr(rld_pkg::OFS_MAIN_CONTROL, 8'h02);
    rld_host_model_inst.wr(rld_pkg::OFS_MAIN_CONTROL, 8'h03);
    nw(1);
    chk("aux_rerun", 8'h03, {6'h0, arun, asoft});
  endtask

  // Reset in mid-run: registers back to defaults, main regulator ramps again
  task automatic t_reset;
    arst_n_in = 1'b0;
    nw(2);
    chk("sel", 8'h02, {5'h0, vsel});
    chk("led", 8'h00, {7'h0, led});
    chk("int_n", 8'h01, {7'h0, int_n});
    chk("run", 8'h00, {6'h0, mrun, arun});
    arst_n_in = 1'b1;
    nw(1);
    chk("main", 8'h03, {6'h0, mrun, msoft});
  endtask

  task automatic t_dim;
    nw(2);
    chk("dim_src", {5'h0, rld_pkg::RLD_DIM_ZERO}, {5'h0, dim.src});
    pwm = 1'b1;
    nw(2);
    chk("dim_src", {5'h0, rld_pkg::RLD_DIM_ANALOG}, {5'h0, dim.src});
    rld_host_model_inst.wr(rld_pkg::OFS_INT_DIM, 8'hab);
    nw(1);
    chk("dim_src", {5'h0, rld_pkg::RLD_DIM_DAC}, {5'h0, dim.src});
    chk("dim_code", 8'h2b, {1'b0, dim.code});
    pwm = 1'b0;
    nw(2);
    chk("dim_src", {5'h0, rld_pkg::RLD_DIM_DAC}, {5'h0, dim.src});
  endtask

  ////////////////////////////////////////
  initial begin
    nw(12);
    arst_n_in = 1'b1;
    nw(1);
    t_select();
    t_start();
    t_short();
    t_fault();
    t_reset();
    t_dim();
    summarize();
  end
endmodule // regulator_led_dim_control_tb

`default_nettype wire
